/* File: hdl/pda_phase_averager.sv */
// Phase detector averager with register port and interrupt
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ns
module pda_phase_averager (
	input  wire logic       core_clk,
	input  wire logic       rstn,
	input  wire logic       core_ce,
	input  wire logic       ref_tick,
	input  wire logic       ref_align,
	input  wire logic [7:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output logic      [7:0] reg_rdata,
	output logic            irq_out_n
);
	typedef struct packed {
		logic        enable;
		logic        irq_allow;
		logic        auto_reacq;
		logic        forced;
		logic        reserved;
		logic        forced_prev;
		logic [15:0] ref_period;
		logic [15:0] ph_period;
		logic [3:0]  avg_exp;
		logic [1:0]  irq_mask;
		logic        timer_flag;
		logic        align_flag;
		logic [30:0] phase_result;
		logic        prev_low;
		logic        prev_high;
		logic        prev_ok;
		logic        reacq_pending;
		logic [7:0]  rdata;
		logic        irq_n;
	} pda_top_t;

	pda_top_t    st;
	pda_top_t    next_st;
	logic [15:0] ref_count;
	logic [15:0] ph_count;
	logic        ref_end;
	logic        ph_end;
	logic [15:0] half_period;
	logic [15:0] quarter;
	logic        sample_low;
	logic        sample_high;
	logic        wrap_jump;
	logic        reacq_now;
	logic        forced_rise;
	logic        align_ev;
	logic        sample_valid;
	logic        abort;
	logic        period_start;
	logic        done;
	logic [30:0] total;

	assign reg_rdata = st.rdata;
	assign irq_out_n = st.irq_n;

	// Reference period counter, advanced by the reference tick
	pda_counter #(
		.WIDTH (pda_pkg::CNT_W)
	) u_ref_counter (
		.core_clk   (core_clk),
		.rstn       (rstn),
		.core_ce    (core_ce),
		.hold       (!st.enable),
		.step       (ref_tick),
		.load       (1'b0),
		.load_value (16'h0000),
		.period     (st.ref_period),
		.count      (ref_count),
		.at_end     (ref_end)
	);

	// Phase counter, advanced on every core clock with core_ce high
	pda_counter #(
		.WIDTH (pda_pkg::CNT_W)
	) u_phase_counter (
		.core_clk   (core_clk),
		.rstn       (rstn),
		.core_ce    (core_ce),
		.hold       (!st.enable),
		.step       (1'b1),
		.load       (reacq_now),
		.load_value (half_period),
		.period     (st.ph_period),
		.count      (ph_count),
		.at_end     (ph_end)
	);

	pda_accum u_accum (
		.core_clk     (core_clk),
		.rstn         (rstn),
		.core_ce      (core_ce),
		.abort        (abort),
		.sample_valid (sample_valid),
		.sample       (ph_count),
		.exponent     (st.avg_exp),
		.period_start (period_start),
		.done         (done),
		.total        (total)
	);

	// Sampling zones near the wrap-around value
	assign half_period = st.ph_period >> 1;
	assign quarter = st.ph_period >> pda_pkg::ZONE_SHIFT;
	assign sample_low = ph_count < quarter;
	assign sample_high = ph_count > (st.ph_period - quarter);

	assign forced_rise = st.forced && !st.forced_prev;
	assign reacq_now = st.reacq_pending && ref_end;
	assign wrap_jump = st.auto_reacq && st.prev_ok && ref_end && !st.reacq_pending
		&& ((st.prev_low && sample_high) || (st.prev_high && sample_low));
	assign align_ev = ref_align && st.enable;
	assign sample_valid = ref_end && !st.reacq_pending && !wrap_jump;
	assign abort = align_ev || wrap_jump || reacq_now || forced_rise || !st.enable;

	always_comb begin
		logic       rd_status;
		logic       clr_timer;
		logic [7:0] rd_mux;
		rd_status = reg_rd && (reg_addr == pda_pkg::ADDR_STATUS);
		clr_timer = rd_status;
		rd_mux = pda_pkg::RDATA_IDLE;
		next_st = st;
		next_st.forced_prev = st.forced;

		// Register writes
		if (reg_wr) begin
			if (reg_addr == pda_pkg::ADDR_CONFIG) begin
				next_st.enable = reg_wdata[pda_pkg::CFG_ENABLE];
				next_st.irq_allow = reg_wdata[pda_pkg::CFG_IRQ];
				next_st.auto_reacq = reg_wdata[pda_pkg::CFG_AUTO];
				next_st.forced = reg_wdata[pda_pkg::CFG_FORCE];
				next_st.reserved = reg_wdata[pda_pkg::CFG_RSVD];
			end else if (reg_addr == pda_pkg::ADDR_STATUS) begin
				clr_timer = clr_timer || reg_wdata[pda_pkg::ST_TIMER];
			end else if (reg_addr == pda_pkg::ADDR_REF_LO) begin
				next_st.ref_period[7:0] = reg_wdata;
			end else if (reg_addr == pda_pkg::ADDR_REF_HI) begin
				next_st.ref_period[15:8] = reg_wdata;
			end else if (reg_addr == pda_pkg::ADDR_PH_LO) begin
				next_st.ph_period[7:0] = reg_wdata;
			end else if (reg_addr == pda_pkg::ADDR_PH_HI) begin
				next_st.ph_period[15:8] = reg_wdata;
			end else if (reg_addr == pda_pkg::ADDR_AVG_EXP) begin
				next_st.avg_exp = reg_wdata[3:0];
			end else if (reg_addr == pda_pkg::ADDR_MASK) begin
				next_st.irq_mask = reg_wdata[1:0];
			end
		end

		// Timer event, set wins over clear
		next_st.timer_flag = (st.timer_flag && !clr_timer) || period_start;

		// Alignment event and phase word update
		if (align_ev) begin
			next_st.align_flag = 1'b1;
		end else if (done) begin
			next_st.align_flag = 1'b0;
		end
		if (done) begin
			next_st.phase_result = total;
		end

		// Reacquisition request, set wins over completion
		next_st.reacq_pending = (st.reacq_pending && !reacq_now) || forced_rise || wrap_jump;
		if (!st.enable) begin
			next_st.prev_ok = 1'b0;
		end else if (ref_end) begin
			next_st.prev_low = sample_low;
			next_st.prev_high = sample_high;
			next_st.prev_ok = sample_valid;
		end

		// Register reads, data in the following cycle
		if (reg_rd) begin
			if (reg_addr == pda_pkg::ADDR_CONFIG) begin
				rd_mux[pda_pkg::CFG_ENABLE] = st.enable;
				rd_mux[pda_pkg::CFG_IRQ] = st.irq_allow;
				rd_mux[pda_pkg::CFG_AUTO] = st.auto_reacq;
				rd_mux[pda_pkg::CFG_FORCE] = st.forced;
				rd_mux[pda_pkg::CFG_RSVD] = st.reserved;
			end else if (reg_addr == pda_pkg::ADDR_STATUS) begin
				rd_mux[pda_pkg::ST_TIMER] = st.timer_flag;
				rd_mux[pda_pkg::ST_ALIGN] = st.align_flag;
			end else if (reg_addr == pda_pkg::ADDR_RESULT0) begin
				rd_mux = st.phase_result[7:0];
			end else if (reg_addr == pda_pkg::ADDR_RESULT1) begin
				rd_mux = st.phase_result[15:8];
			end else if (reg_addr == pda_pkg::ADDR_RESULT2) begin
				rd_mux = st.phase_result[23:16];
			end else if (reg_addr == pda_pkg::ADDR_RESULT3) begin
				rd_mux = {1'b0, st.phase_result[30:24]};
			end else if (reg_addr == pda_pkg::ADDR_REF_LO) begin
				rd_mux = st.ref_period[7:0];
			end else if (reg_addr == pda_pkg::ADDR_REF_HI) begin
				rd_mux = st.ref_period[15:8];
			end else if (reg_addr == pda_pkg::ADDR_PH_LO) begin
				rd_mux = st.ph_period[7:0];
			end else if (reg_addr == pda_pkg::ADDR_PH_HI) begin
				rd_mux = st.ph_period[15:8];
			end else if (reg_addr == pda_pkg::ADDR_AVG_EXP) begin
				rd_mux = {4'h0, st.avg_exp};
			end else if (reg_addr == pda_pkg::ADDR_MASK) begin
				rd_mux = {6'h00, st.irq_mask};
			end
		end
		next_st.rdata = rd_mux;

		// Interrupt, gated by mask and interrupt allow
		next_st.irq_n = !(next_st.irq_allow
			&& |({next_st.align_flag, next_st.timer_flag} & next_st.irq_mask));
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			st <= '0;
			st.enable <= pda_pkg::CFG_RST;
			st.irq_allow <= pda_pkg::CFG_RST;
			st.auto_reacq <= pda_pkg::CFG_RST;
			st.forced <= pda_pkg::CFG_RST;
			st.reserved <= pda_pkg::CFG_RST;
			st.forced_prev <= pda_pkg::CFG_RST;
			st.ref_period <= pda_pkg::PERIOD_RST;
			st.ph_period <= pda_pkg::PERIOD_RST;
			st.avg_exp <= pda_pkg::EXP_RST;
			st.irq_mask <= pda_pkg::MASK_RST;
			st.rdata <= pda_pkg::RDATA_IDLE;
			st.irq_n <= 1'b1;
		end else if (core_ce) begin
			st <= next_st;
		end
	end

	// Checks
	idle_hold_a: assert property (@(posedge core_clk) disable iff (!rstn)
		core_ce && !st.enable |=> ref_count == 16'h0000 && ph_count == 16'h0000)
		else $error("counters run while comparison disabled");

	irq_gate_a: assert property (@(posedge core_clk) disable iff (!rstn)
		!st.irq_allow |-> st.irq_n)
		else $error("interrupt raised while not allowed");

	timer_set_a: assert property (@(posedge core_clk) disable iff (!rstn)
		core_ce && period_start |=> st.timer_flag)
		else $error("timer flag missed at averaging start");

	read_clear_a: assert property (@(posedge core_clk) disable iff (!rstn)
		core_ce && reg_rd && reg_addr == pda_pkg::ADDR_STATUS && !period_start
		|=> !st.timer_flag)
		else $error("status read did not clear timer flag");

	align_freeze_a: assert property (@(posedge core_clk) disable iff (!rstn)
		core_ce && align_ev |=> st.align_flag && $stable(st.phase_result))
		else $error("alignment did not set flag or freeze word");

	align_clear_a: assert property (@(posedge core_clk) disable iff (!rstn)
		core_ce && done |=> !st.align_flag)
		else $error("alignment flag kept after valid average");

	result_load_a: assert property (@(posedge core_clk) disable iff (!rstn)
		core_ce && done |=> st.phase_result == $past(total))
		else $error("phase word not loaded with the sum");

	word_hold_a: assert property (@(posedge core_clk) disable iff (!rstn)
		core_ce && wrap_jump |=> st.reacq_pending && $stable(st.phase_result))
		else $error("wrap straddle not handled");

	recentre_a: assert property (@(posedge core_clk) disable iff (!rstn)
		core_ce && reacq_now |=> ph_count == $past(half_period))
		else $error("sampling point not moved to mid period");

	forced_edge_a: assert property (@(posedge core_clk) disable iff (!rstn)
		core_ce && st.forced && !st.forced_prev |=> st.reacq_pending && st.forced_prev)
		else $error("forced edge did not start reacquisition");

	top_bit_a: assert property (@(posedge core_clk) disable iff (!rstn)
		reg_rd && reg_addr == pda_pkg::ADDR_RESULT3 ##1 1'b1 |-> !reg_rdata[7])
		else $error("unused phase word bit reads one");

	// Flag, counter and readback checks
	irq_level_a: assert property (@(posedge core_clk) disable iff (!rstn)
		st.irq_n == !(st.irq_allow && ((st.timer_flag && st.irq_mask[0])
		|| (st.align_flag && st.irq_mask[1]))))
		else $error("interrupt level disagrees with flags");

	timer_keep_a: assert property (@(posedge core_clk) disable iff (!rstn)
		core_ce && st.timer_flag
		&& !(reg_addr == pda_pkg::ADDR_STATUS && (reg_rd || reg_wr)) |=> st.timer_flag)
		else $error("timer flag lost without a clear");

	timer_source_a: assert property (@(posedge core_clk) disable iff (!rstn)
		core_ce && !st.timer_flag && !period_start |=> !st.timer_flag)
		else $error("timer flag set outside averaging start");

	align_keep_a: assert property (@(posedge core_clk) disable iff (!rstn)
		core_ce && st.align_flag && !done |=> st.align_flag)
		else $error("alignment flag cleared early");

	align_source_a: assert property (@(posedge core_clk) disable iff (!rstn)
		core_ce && !st.align_flag && !align_ev |=> !st.align_flag)
		else $error("alignment flag set without alignment");

	abort_align_a: assert property (@(posedge core_clk) disable iff (!rstn)
		align_ev |-> abort && !done)
		else $error("alignment did not abort averaging");

	word_still_a: assert property (@(posedge core_clk) disable iff (!rstn)
		core_ce && !done |=> $stable(st.phase_result))
		else $error("phase word changed without completion");

	idle_quiet_a: assert property (@(posedge core_clk) disable iff (!rstn)
		!st.enable |-> !sample_valid && !period_start && !done)
		else $error("sampling while comparison disabled");

	ref_step_a: assert property (@(posedge core_clk) disable iff (!rstn)
		core_ce && st.enable && ref_tick && !ref_end
		|=> ref_count == $past(ref_count) + 16'h0001)
		else $error("reference counter missed a tick");

	ref_still_a: assert property (@(posedge core_clk) disable iff (!rstn)
		core_ce && st.enable && !ref_tick |=> $stable(ref_count))
		else $error("reference counter moved without a tick");

	phase_step_a: assert property (@(posedge core_clk) disable iff (!rstn)
		core_ce && st.enable && !ph_end && !reacq_now
		|=> ph_count == $past(ph_count) + 16'h0001)
		else $error("phase counter did not advance");

	pending_gate_a: assert property (@(posedge core_clk) disable iff (!rstn)
		st.reacq_pending |-> !sample_valid && !done)
		else $error("sample taken while reacquisition pending");

	edge_memory_a: assert property (@(posedge core_clk) disable iff (!rstn)
		core_ce |=> st.forced_prev == $past(st.forced))
		else $error("forced bit history not kept");

	pending_end_a: assert property (@(posedge core_clk) disable iff (!rstn)
		core_ce && reacq_now && !forced_rise |=> !st.reacq_pending)
		else $error("reacquisition did not finish");

	auto_off_a: assert property (@(posedge core_clk) disable iff (!rstn)
		!st.auto_reacq |-> !wrap_jump)
		else $error("wrap straddle acted on in manual mode");

	result_byte_a: assert property (@(posedge core_clk) disable iff (!rstn)
		core_ce && reg_rd && reg_addr == pda_pkg::ADDR_RESULT0
		|=> reg_rdata == $past(st.phase_result[7:0]))
		else $error("low phase word byte misread");
endmodule

/* File: hdl/pda_pkg.sv */
// Constants for the phase detector averager
// Summary of operation
// - Enable low holds both counters in reset
// - Interrupt output only while interrupt allow set
// - Auto mode recentres sampling after wrap straddle
// - Forced bit rising starts one reacquisition
// - Timer flag set at each averaging start
// - Status read clears the timer flag
// - Alignment sets flag, aborts, freezes phase word
// - Valid averaging completion clears alignment flag
// - Phase word is four bytes, LSB first
// - Low bits fraction, next sixteen integer part
// - Reference counter counts period plus one
// - Phase counter counts period plus one
// - Word sums two-power-exponent valid samples
package pda_pkg;
	localparam logic [7:0]  ADDR_CONFIG   = 8'hd0;
	localparam logic [7:0]  ADDR_STATUS   = 8'hd1;
	localparam logic [7:0]  ADDR_RESULT0  = 8'hd2;
	localparam logic [7:0]  ADDR_RESULT1  = 8'hd3;
	localparam logic [7:0]  ADDR_RESULT2  = 8'hd4;
	localparam logic [7:0]  ADDR_RESULT3  = 8'hd5;
	localparam logic [7:0]  ADDR_REF_LO   = 8'hd9;
	localparam logic [7:0]  ADDR_REF_HI   = 8'hda;
	localparam logic [7:0]  ADDR_PH_LO    = 8'hdb;
	localparam logic [7:0]  ADDR_PH_HI    = 8'hdc;
	localparam logic [7:0]  ADDR_AVG_EXP  = 8'hdd;
	localparam logic [7:0]  ADDR_MASK     = 8'hde;
	localparam int          CFG_ENABLE    = 0;
	localparam int          CFG_IRQ       = 1;
	localparam int          CFG_AUTO      = 2;
	localparam int          CFG_FORCE     = 3;
	localparam int          CFG_RSVD      = 7;
	localparam int          ST_TIMER      = 0;
	localparam int          ST_ALIGN      = 1;
	localparam int          CNT_W         = 16;
	localparam int          EXP_W         = 4;
	localparam int          RESULT_W      = 31;
	localparam int          ZONE_SHIFT    = 2;
	localparam logic        CFG_RST       = 1'b0;
	localparam logic [1:0]  MASK_RST      = 2'h3;
	localparam logic [15:0] PERIOD_RST    = 16'h0000;
	localparam logic [3:0]  EXP_RST       = 4'h0;
	localparam logic [7:0]  RDATA_IDLE    = 8'h00;
endpackage

/* File: hdl/pda_counter.sv */
// Modulo counter with hold, load and end-of-count detection
`timescale 1ns/1ns
module pda_counter #(
	parameter int WIDTH = 16
) (
	input  wire logic             core_clk,
	input  wire logic             rstn,
	input  wire logic             core_ce,
	input  wire logic             hold,
	input  wire logic             step,
	input  wire logic             load,
	input  wire logic [WIDTH-1:0] load_value,
	input  wire logic [WIDTH-1:0] period,
	output logic      [WIDTH-1:0] count,
	output logic                  at_end
);
	typedef struct packed {
		logic [WIDTH-1:0] value;
	} pda_counter_t;

	pda_counter_t st;
	pda_counter_t next_st;

	assign count = st.value;
	assign at_end = step && !hold && (st.value == period);

	always_comb begin
		next_st = st;
		if (hold) begin
			next_st.value = '0;
		end else if (load) begin
			next_st.value = load_value;
		end else if (at_end) begin
			next_st.value = '0;
		end else if (step) begin
			next_st.value = st.value + 1'b1;
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			st <= '0;
		end else if (core_ce) begin
			st <= next_st;
		end
	end

	count_wrap_a: assert property (@(posedge core_clk) disable iff (!rstn)
		core_ce && at_end && !load |=> st.value == '0)
		else $error("counter did not restart after end of count");
endmodule

/* File: hdl/pda_accum.sv */
// Sample accumulator over a power-of-two averaging period
`timescale 1ns/1ns
module pda_accum (
	input  wire logic        core_clk,
	input  wire logic        rstn,
	input  wire logic        core_ce,
	input  wire logic        abort,
	input  wire logic        sample_valid,
	input  wire logic [15:0] sample,
	input  wire logic [3:0]  exponent,
	output logic             period_start,
	output logic             done,
	output logic      [30:0] total
);
	typedef struct packed {
		logic [30:0] acc;
		logic [14:0] cnt;
	} pda_accum_t;

	pda_accum_t  st;
	pda_accum_t  next_st;
	logic [15:0] span;
	logic        last;
	logic        take;

	assign span = 16'h0001 << exponent;
	assign last = {1'b0, st.cnt} == (span - 16'h0001);
	assign take = sample_valid && !abort;
	assign total = st.acc + {15'h0000, sample};
	assign period_start = take && (st.cnt == 15'h0000);
	assign done = take && last;

	always_comb begin
		next_st = st;
		if (abort) begin
			next_st = '0;
		end else if (take) begin
			if (last) begin
				next_st = '0;
			end else begin
				next_st.acc = total;
				next_st.cnt = st.cnt + 15'h0001;
			end
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			st <= '0;
		end else if (core_ce) begin
			st <= next_st;
		end
	end

	restart_count_a: assert property (@(posedge core_clk) disable iff (!rstn)
		core_ce && (abort || done) |=> st.cnt == 15'h0000 && st.acc == 31'h00000000)
		else $error("accumulator not restarted");
endmodule

/* File: bench/phase_detector_averager_tb.sv */
// Self-checking bench for the phase detector averager
`timescale 1ns/1ns
module phase_detector_averager_tb;
	localparam int PER = 1024;
	logic        core_clk;
	logic        rstn;
	logic        core_ce;
	logic        ref_tick;
	logic        ref_align;
	logic [7:0]  reg_addr;
	logic [7:0]  reg_wdata;
	logic        reg_wr;
	logic        reg_rd;
	logic [7:0]  reg_rdata;
	logic        irq_out_n;
	int          num_errors;
	int          checks;
	int          cyc;
	int          base;
	int          eb;
	int          last;
	logic [31:0] w;
	logic [7:0]  d;

	pda_phase_averager uut (
		.core_clk  (core_clk),
		.rstn      (rstn),
		.core_ce   (core_ce),
		.ref_tick  (ref_tick),
		.ref_align (ref_align),
		.reg_addr  (reg_addr),
		.reg_wdata (reg_wdata),
		.reg_wr    (reg_wr),
		.reg_rd    (reg_rd),
		.reg_rdata (reg_rdata),
		.irq_out_n (irq_out_n)
	);

	initial begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end

	always @(posedge core_clk) begin
		cyc <= cyc + 1;
	end

	task automatic finish_test();
		$display("Errors %0d, checks %0d", num_errors, checks);
		if (num_errors == 0 && checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge core_clk);
		reg_addr  <= a;
		reg_wdata <= v;
		reg_wr    <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		@(negedge core_clk);
		d = reg_rdata;
	endtask

	task automatic rd_word();
		for (int i = 0; i < 4; i++) begin
			rd(pda_pkg::ADDR_RESULT0 + 8'(i));
			w[8*i +: 8] = d;
		end
	endtask

	// Phase count seen at a sampling edge, from the last known anchor
	function automatic int ph(input int e);
		return (base + e - eb) % (PER + 1);
	endfunction

	// Tick landing on a target phase, or at once when target is negative
	task automatic tick_at(input int tgt);
		int n;
		n = 0;
		@(posedge core_clk);
		while (tgt >= 0 && ph(cyc + 1) != tgt && n < 2100) begin
			@(posedge core_clk);
			n++;
		end
		ref_tick <= 1'b1;
		@(posedge core_clk);
		ref_tick <= 1'b0;
		last = cyc;
	endtask

	task automatic t_reset();
		@(negedge core_clk);
		chk("irq idle", 32'h1, irq_out_n);
		rd(pda_pkg::ADDR_CONFIG);
		chk("config reset", 32'h0, d);
		rd(pda_pkg::ADDR_MASK);
		chk("mask reset", 32'(pda_pkg::MASK_RST), d);
		rd_word();
		chk("word reset", 32'h0, w);
	endtask

	task automatic t_setup();
		wr(pda_pkg::ADDR_PH_LO, 8'h00);
		wr(pda_pkg::ADDR_PH_HI, 8'h04);
		wr(pda_pkg::ADDR_CONFIG, 8'h01);
		rd(pda_pkg::ADDR_PH_HI);
		chk("period hi", 32'h4, d);
		rd(pda_pkg::ADDR_CONFIG);
		chk("config", 32'h1, d);
		@(negedge core_clk);
		chk("rdata idle", 32'h0, reg_rdata);
		wr(pda_pkg::ADDR_RESULT0, 8'hff);
		rd(8'hff);
		chk("unmapped", 32'h0, d);
		rd(pda_pkg::ADDR_RESULT0);
		chk("word read only", 32'h0, d);
	endtask

	task automatic t_base();
		tick_at(-1);
		rd_word();
		base = int'(w);
		eb = last;
		chk("word top", 32'h0, {16'h0000, w[31:16]});
		rd(pda_pkg::ADDR_STATUS);
		chk("timer set", 32'h1, d);
		rd(pda_pkg::ADDR_STATUS);
		chk("timer cleared", 32'h0, d);
		chk("irq off", 32'h1, irq_out_n);
	endtask

	task automatic t_wrap();
		tick_at(1000);
		rd_word();
		chk("sample", 32'd1000, w);
		@(posedge core_clk);
		core_ce <= 1'b0;
		repeat (10) @(posedge core_clk);
		core_ce <= 1'b1;
		eb = eb + 10;
		tick_at(5);
		rd_word();
		chk("sample wrap", 32'd5, w);
	endtask

	task automatic t_irq();
		wr(pda_pkg::ADDR_CONFIG, 8'h03);
		tick_at(-1);
		repeat (3) @(negedge core_clk);
		chk("irq on", 32'h0, irq_out_n);
		wr(pda_pkg::ADDR_MASK, 8'h00);
		repeat (2) @(negedge core_clk);
		chk("irq masked", 32'h1, irq_out_n);
		wr(pda_pkg::ADDR_MASK, 8'h03);
		rd(pda_pkg::ADDR_STATUS);
		chk("status", 32'h1, d);
		repeat (2) @(negedge core_clk);
		chk("irq cleared", 32'h1, irq_out_n);
		tick_at(-1);
		wr(pda_pkg::ADDR_STATUS, 8'h01);
		rd(pda_pkg::ADDR_STATUS);
		chk("status write clear", 32'h0, d);
	endtask

	task automatic t_avg();
		wr(pda_pkg::ADDR_AVG_EXP, 8'h01);
		tick_at(100);
		tick_at(300);
		rd(pda_pkg::ADDR_STATUS);
		chk("poll timer", 32'h1, d);
		rd_word();
		chk("average", 32'd400, w);
	endtask

	task automatic t_align();
		tick_at(50);
		@(posedge core_clk);
		ref_align <= 1'b1;
		@(posedge core_clk);
		ref_align <= 1'b0;
		rd(pda_pkg::ADDR_STATUS);
		chk("align set", 32'h3, d);
		rd_word();
		chk("word frozen", 32'd400, w);
		tick_at(10);
		tick_at(20);
		rd_word();
		chk("average again", 32'd30, w);
		rd(pda_pkg::ADDR_STATUS);
		chk("align cleared", 32'h1, d);
	endtask

	task automatic t_force();
		wr(pda_pkg::ADDR_AVG_EXP, 8'h00);
		wr(pda_pkg::ADDR_CONFIG, 8'h0b);
		tick_at(200);
		base = PER / 2 - 1;
		eb = last;
		rd_word();
		chk("forced discard", 32'd30, w);
		tick_at(700);
		rd_word();
		chk("forced recentre", 32'd700, w);
		wr(pda_pkg::ADDR_CONFIG, 8'h0b);
		tick_at(900);
		rd_word();
		chk("no second force", 32'd900, w);
	endtask

	task automatic t_auto();
		wr(pda_pkg::ADDR_CONFIG, 8'h07);
		tick_at(900);
		tick_at(100);
		rd_word();
		chk("auto hold", 32'd900, w);
		tick_at(400);
		base = PER / 2 - 1;
		eb = last;
		rd_word();
		chk("auto discard", 32'd900, w);
		tick_at(600);
		rd_word();
		chk("auto recentre", 32'd600, w);
	endtask

	task automatic t_reference_period();
		wr(pda_pkg::ADDR_CONFIG, 8'h00);
		rd(pda_pkg::ADDR_STATUS);
		tick_at(-1);
		rd(pda_pkg::ADDR_STATUS);
		chk("disabled", 32'h0, d);
		wr(pda_pkg::ADDR_REF_LO, 8'h02);
		wr(pda_pkg::ADDR_CONFIG, 8'h01);
		for (int i = 0; i < 3; i++) begin
			tick_at(-1);
			rd(pda_pkg::ADDR_STATUS);
			chk("ref count", (i == 2) ? 32'h1 : 32'h0, d);
		end
	endtask

	initial begin
		repeat (40000) @(posedge core_clk);
		num_errors++;
		finish_test();
	end

	initial begin
		num_errors = 0;
		checks = 0;
		cyc = 0;
		base = 0;
		eb = 0;
		last = 0;
		rstn = 1'b0;
		core_ce = 1'b1;
		ref_tick = 1'b0;
		ref_align = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		repeat (12) @(posedge core_clk);
		rstn <= 1'b1;
		t_reset();
		t_setup();
		t_base();
		t_wrap();
		t_irq();
		t_avg();
		t_align();
		t_force();
		t_auto();
		t_reference_period();
		finish_test();
	end
endmodule
